// ### rtl/cpg_pkg.sv
/*
 * Constants, types and register map of the counter pwm/fm generator.
 * Assumes a 50 MHz APB clock and that every user of a name writes cpg_pkg::name.
 */
// Notes on behaviour
// - five separate channels, each with own settings.
// - each channel picks one of five base ticks.
// - pulse-width mode: fixed frequency, input sets duty.
// - output frequency equals base times relative value.
// - level order picks high-first or low-first period.
// - duty always sets length of high phase.
// - disarmed channel drives configured static level.
// - plain modes arm only while application runs.
// - arm mode: arm input at half arms channel while application runs.
// - frequency mode: input sets frequency, duty constant.
// - frequency mode duty is the configured constant.
// - each channel drives its own output pin.
package cpg_pkg;

   // ==========================================================================
   // Clocking
   localparam int CLK_HZ = 50_000_000;
   localparam int REF_HZ = 1_000_000;
   localparam int REF_DIV = CLK_HZ / REF_HZ;
   localparam int DEC_DIV = 10;
   localparam int NUM_BASE = 5;
   localparam int NUM_CH = 5;

   // ==========================================================================
   // Fractions are unsigned with 16 fraction bits; 17'h10000 stands for one.
   localparam int FRAC_W = 17;
   localparam logic [16:0] FRAC_ONE = 17'h10000;
   localparam logic [16:0] FRAC_HALF = 17'h08000;
   localparam int CNT_W = 16;

   // ==========================================================================
   // Register map, byte addresses.
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_CH_BASE = 12'h020;
   localparam logic [11:0] ADDR_CH_END = 12'h0c0;
   localparam logic [4:0] OFS_CFG = 5'h00;
   localparam logic [4:0] OFS_FIXED = 5'h04;
   localparam logic [4:0] OFS_INPUT = 5'h08;
   localparam logic [4:0] OFS_ARM = 5'h0c;
   localparam logic [4:0] OFS_COUNT = 5'h10;

   // Field positions of the channel configuration word.
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_BASE_LSB = 2;
   localparam int CFG_ORDER_BIT = 5;
   localparam int CFG_IDLE_BIT = 6;
   localparam int CFG_W = 7;
   localparam int CTRL_RUN_BIT = 0;

   // Values after reset.
   localparam logic [6:0] CFG_RST = 7'h00;
   localparam logic [16:0] FIXED_RST = 17'h08000;
   localparam logic [16:0] INPUT_RST = 17'h00000;
   localparam logic [16:0] ARM_RST = 17'h00000;

   typedef enum logic [1:0] {
      CPG_MODE_PWM, CPG_MODE_PWM_ARM, CPG_MODE_FM, CPG_MODE_SPARE
   } cpg_mode_t;

   typedef enum logic [2:0] {
      base_clock_sel_1mhz, base_clock_sel_100khz, base_clock_sel_10khz,
      base_clock_sel_1khz, base_clock_sel_100hz
   } cpg_base_t;

endpackage : cpg_pkg

// ### rtl/cpg_tick_if.sv
/*
 * Carries the five base-rate tick pulses from the timebase to the channels.
 * Assumes a single clock domain shared by both ends.
 */
`timescale 1ns/1ps
interface cpg_tick_if;
   logic [cpg_pkg::NUM_BASE-1:0] tick;
   modport src (output tick);
   modport sink (input tick);
endinterface : cpg_tick_if

// ### rtl/cpg_timebase.sv
/*
 * Timebase: divides pclk to a 1 MHz reference and then by decades.
 * Assumes pclk at the rate given in the package; ticks are one-cycle pulses.
 */
`timescale 1ns/1ps
module cpg_timebase (
   input wire logic pclk, // APB clock
   input wire logic presetn, // asynchronous reset, active low
   cpg_tick_if.src ticks // base-rate tick pulses
);

   // ==========================================================================
   // Reference divider
   logic [5:0] ref_cnt_r;
   logic [cpg_pkg::NUM_BASE-1:0] tick_r;
   logic [3:0] dec_cnt_r [1:cpg_pkg::NUM_BASE-1];

   // All five rates hang off one 1 MHz reference, as the counters expect.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_cnt_r <= 6'h00;
         tick_r[0] <= 1'b0;
      end else begin
         tick_r[0] <= (ref_cnt_r == 6'(cpg_pkg::REF_DIV - 1));
         if (ref_cnt_r == 6'(cpg_pkg::REF_DIV - 1)) begin
            ref_cnt_r <= 6'h00;
         end else begin
            ref_cnt_r <= ref_cnt_r + 6'h01;
         end
      end
   end

   // ==========================================================================
   // Decade chain: 100 kHz, 10 kHz, 1 kHz and 100 Hz.
   for (genvar k = 1; k < cpg_pkg::NUM_BASE; k++) begin : g_dec
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            dec_cnt_r[k] <= 4'h0;
            tick_r[k] <= 1'b0;
         end else begin
            tick_r[k] <= tick_r[k-1] && (dec_cnt_r[k] == 4'(cpg_pkg::DEC_DIV - 1));
            if (tick_r[k-1]) begin
               if (dec_cnt_r[k] == 4'(cpg_pkg::DEC_DIV - 1)) begin
                  dec_cnt_r[k] <= 4'h0;
               end else begin
                  dec_cnt_r[k] <= dec_cnt_r[k] + 4'h1;
               end
            end
         end
      end
   end

   assign ticks.tick = tick_r;

endmodule : cpg_timebase

// ### rtl/cpg_top.sv
/*
 * Five-channel counter waveform generator with an APB register file.
 * Each channel makes pulse-width or frequency modulated square waves.
 * Assumes an APB master on pclk; the output pins feed external loads.
 */
`timescale 1ns/1ps
module cpg_top (
   input wire logic pclk, // APB clock, 50 MHz
   input wire logic presetn, // asynchronous reset, active low
   input wire logic [11:0] paddr, // APB byte address
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB write when high
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready, one wait state
   output logic pslverr, // APB error on unmapped address
   output logic [cpg_pkg::NUM_CH-1:0] pwm_out // counter output pins
);

   // ==========================================================================
   // Address decode helpers
   function automatic logic ch_hit(input logic [11:0] a);
      logic [11:0] d;
      d = a - cpg_pkg::ADDR_CH_BASE;
      ch_hit = (a >= cpg_pkg::ADDR_CH_BASE) && (a < cpg_pkg::ADDR_CH_END)
               && (a[1:0] == 2'h0) && (d[4:0] <= cpg_pkg::OFS_COUNT);
   endfunction : ch_hit

   function automatic logic [2:0] ch_idx(input logic [11:0] a);
      logic [11:0] d;
      d = a - cpg_pkg::ADDR_CH_BASE;
      ch_idx = d[7:5];
   endfunction : ch_idx

   // Register offset inside a channel window; windows lie 32 bytes apart.
   function automatic logic [4:0] ch_ofs(input logic [11:0] a);
      logic [11:0] d;
      d = a - cpg_pkg::ADDR_CH_BASE;
      ch_ofs = d[4:0];
   endfunction : ch_ofs

   // Values above one are saturated so a period can never hold more than one.
   function automatic logic [16:0] clamp_frac(input logic [31:0] v);
      clamp_frac = (v > 32'(cpg_pkg::FRAC_ONE)) ? cpg_pkg::FRAC_ONE : v[16:0];
   endfunction : clamp_frac

   // Illegal base codes fall back to the fastest rate.
   function automatic logic [2:0] base_idx(input logic [2:0] s);
      unique case (s)
         cpg_pkg::base_clock_sel_1mhz: base_idx = 3'h0;
         cpg_pkg::base_clock_sel_100khz: base_idx = 3'h1;
         cpg_pkg::base_clock_sel_10khz: base_idx = 3'h2;
         cpg_pkg::base_clock_sel_1khz: base_idx = 3'h3;
         cpg_pkg::base_clock_sel_100hz: base_idx = 3'h4;
         default: base_idx = 3'h0;
      endcase
   endfunction : base_idx

   // ==========================================================================
   // APB slave handshake
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;

   logic access;
   logic commit;
   logic addr_ok;
   logic [31:0] rd_word;

   assign access = psel && penable;
   // A request is taken at the edge where the master sees pready high.
   assign commit = access && pready_r;
   assign addr_ok = (paddr == cpg_pkg::ADDR_CTRL) || (paddr == cpg_pkg::ADDR_STATUS)
                    || ch_hit(paddr);

   // Ready rises one cycle into the access phase and drops the cycle after.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= access && !pready_r;
      end
   end

   // Read data and error are captured on the same edge that raises ready, so both leave
   // from flip-flops; the price is one fixed wait state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (access && !pready_r) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
         pslverr_r <= !addr_ok;
      end else begin
         pslverr_r <= 1'b0;
      end
   end

   // ==========================================================================
   // Software registers
   logic run_r;
   logic [cpg_pkg::CFG_W-1:0] cfg_r [cpg_pkg::NUM_CH];
   logic [16:0] fixed_r [cpg_pkg::NUM_CH];
   logic [16:0] input_r [cpg_pkg::NUM_CH];
   logic [16:0] arm_in_r [cpg_pkg::NUM_CH];
   logic wr_ch;
   logic [2:0] wr_idx;
   logic [4:0] wr_ofs;

   // STATUS and COUNT writes fall through with no effect and no error.
   assign wr_ch = commit && pwrite && ch_hit(paddr);
   assign wr_idx = ch_idx(paddr);
   assign wr_ofs = ch_ofs(paddr);

   // The run bit stands for the controlling application being started.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 1'b0;
      end else if (commit && pwrite && (paddr == cpg_pkg::ADDR_CTRL)) begin
         run_r <= pwdata[cpg_pkg::CTRL_RUN_BIT];
      end
   end

   // Each channel owns its own copy of every setting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < cpg_pkg::NUM_CH; i++) begin
            cfg_r[i] <= cpg_pkg::CFG_RST;
            fixed_r[i] <= cpg_pkg::FIXED_RST;
            input_r[i] <= cpg_pkg::INPUT_RST;
            arm_in_r[i] <= cpg_pkg::ARM_RST;
         end
      end else if (wr_ch) begin
         for (int i = 0; i < cpg_pkg::NUM_CH; i++) begin
            if (wr_idx == 3'(i)) begin
               if (wr_ofs == cpg_pkg::OFS_CFG) begin
                  cfg_r[i] <= pwdata[cpg_pkg::CFG_W-1:0];
               end
               // The fixed setting is refused while running, so a running channel
               // never changes its step in pulse-width modes, nor its duty in frequency mode.
               if ((wr_ofs == cpg_pkg::OFS_FIXED) && !run_r) begin
                  fixed_r[i] <= clamp_frac(pwdata);
               end
               // The host refreshes this once per sample period; it is held between.
               if (wr_ofs == cpg_pkg::OFS_INPUT) begin
                  input_r[i] <= clamp_frac(pwdata);
               end
               if (wr_ofs == cpg_pkg::OFS_ARM) begin
                  arm_in_r[i] <= clamp_frac(pwdata);
               end
            end
         end
      end
   end

   // ==========================================================================
   // Timebase
   // One timebase serves all channels, so equal rates stay in step.
   cpg_tick_if tick_bus ();

   cpg_timebase u_timebase (
      .pclk (pclk),
      .presetn (presetn),
      .ticks (tick_bus.src)
   );

   // ==========================================================================
   // Channel engines
   logic [cpg_pkg::NUM_CH-1:0] armed_v;
   logic [cpg_pkg::NUM_CH-1:0] out_v;
   logic [cpg_pkg::NUM_CH-1:0] pend_v;
   logic [cpg_pkg::CNT_W-1:0] periods_v [cpg_pkg::NUM_CH];

   for (genvar g = 0; g < cpg_pkg::NUM_CH; g++) begin : g_ch
      cpg_pkg::cpg_mode_t mode;
      logic tick;
      logic armed;
      logic [16:0] step_live;
      logic [16:0] duty_live;
      logic [17:0] sum;
      logic wrap;
      logic [16:0] acc_nxt;
      logic high;
      logic upd;

      logic [16:0] acc_r;
      logic [16:0] step_sh_r;
      logic [16:0] duty_sh_r;
      logic out_r;
      logic armed_r;
      logic pend_r;
      logic [cpg_pkg::CNT_W-1:0] periods_r;

      assign mode = cpg_pkg::cpg_mode_t'(cfg_r[g][cpg_pkg::CFG_MODE_LSB +: 2]);
      // The selected base rate steps the phase; nothing moves between ticks.
      assign tick = tick_bus.tick[base_idx(cfg_r[g][cpg_pkg::CFG_BASE_LSB +: 3])];

      // Arming follows the run bit, and in arm mode also the arm input.
      // The spare mode code behaves as plain pulse width.
      always_comb begin
         unique case (mode)
            cpg_pkg::CPG_MODE_PWM_ARM: armed = run_r && (arm_in_r[g] >= cpg_pkg::FRAC_HALF);
            cpg_pkg::CPG_MODE_PWM: armed = run_r;
            cpg_pkg::CPG_MODE_FM: armed = run_r;
            cpg_pkg::CPG_MODE_SPARE: armed = run_r;
         endcase
      end

      // In frequency mode the input is the rate and the duty is fixed.
      // Otherwise the rate is fixed and the input is the duty.
      always_comb begin
         if (mode == cpg_pkg::CPG_MODE_FM) begin
            step_live = input_r[g];
            duty_live = fixed_r[g];
         end else begin
            step_live = fixed_r[g];
            duty_live = input_r[g];
         end
      end

      // One period is one wrap of a phase accumulator stepped by the relative
      // frequency, so the output rate is the base rate times that fraction.
      assign sum = {1'b0, acc_r} + {1'b0, step_sh_r};
      assign wrap = sum >= {1'b0, cpg_pkg::FRAC_ONE};
      // Subtracting one keeps the remainder, so no fraction of a step is lost.
      assign acc_nxt = wrap ? 17'(sum - {1'b0, cpg_pkg::FRAC_ONE}) : sum[16:0];

      // The duty fraction is always the high share of the period, whichever
      // half comes first.
      always_comb begin
         if (cfg_r[g][cpg_pkg::CFG_ORDER_BIT]) begin
            high = ({1'b0, acc_r} + {1'b0, duty_sh_r}) >= {1'b0, cpg_pkg::FRAC_ONE};
         end else begin
            high = acc_r < duty_sh_r;
         end
      end

      // Shadows load only at a period boundary, so a mid-period write never
      // cuts a pulse short. While disarmed they follow the live values.
      assign upd = !armed || (tick && wrap);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            step_sh_r <= cpg_pkg::FIXED_RST;
            duty_sh_r <= cpg_pkg::INPUT_RST;
         end else if (upd) begin
            step_sh_r <= step_live;
            duty_sh_r <= duty_live;
         end
      end

      // Arming restarts the period from its first phase.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            acc_r <= 17'h00000;
         end else if (!armed) begin
            acc_r <= 17'h00000;
         end else if (tick) begin
            acc_r <= acc_nxt;
         end
      end

      // Reset leaves the channel disarmed at its static level.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_r <= 1'b0;
            armed_r <= 1'b0;
         end else begin
            armed_r <= armed;
            out_r <= armed ? high : cfg_r[g][cpg_pkg::CFG_IDLE_BIT];
         end
      end

      // A write waiting for the next boundary; a new write wins over the clear.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_r <= 1'b0;
         end else if (wr_ch && (wr_idx == 3'(g)) && armed
                      && (wr_ofs == cpg_pkg::OFS_INPUT)) begin
            pend_r <= 1'b1;
         end else if (upd) begin
            pend_r <= 1'b0;
         end
      end

      // The tally wraps after 65536 periods and restarts on every disarm.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            periods_r <= '0;
         end else if (!armed) begin
            periods_r <= '0;
         end else if (tick && wrap) begin
            periods_r <= periods_r + 16'h0001;
         end
      end

      assign armed_v[g] = armed_r;
      assign out_v[g] = out_r;
      assign pend_v[g] = pend_r;
      assign periods_v[g] = periods_r;
   end

   // ==========================================================================
   // Read mux
   logic [2:0] rd_idx;

   assign rd_idx = ch_idx(paddr);

   // The word depends on the address and the registers, not the handshake, so it has settled well before the
   // first access edge captures it.
   always_comb begin
      rd_word = 32'h0000_0000;
      if (paddr == cpg_pkg::ADDR_CTRL) begin
         rd_word[cpg_pkg::CTRL_RUN_BIT] = run_r;
      end else if (paddr == cpg_pkg::ADDR_STATUS) begin
         // Armed flags, then pin levels, then pending updates.
         rd_word[14:0] = {pend_v, out_v, armed_v};
      end else if (ch_hit(paddr)) begin
         for (int i = 0; i < cpg_pkg::NUM_CH; i++) begin
            if (rd_idx == 3'(i)) begin
               unique case (ch_ofs(paddr))
                  cpg_pkg::OFS_CFG: rd_word[cpg_pkg::CFG_W-1:0] = cfg_r[i];
                  cpg_pkg::OFS_FIXED: rd_word[16:0] = fixed_r[i];
                  cpg_pkg::OFS_INPUT: rd_word[16:0] = input_r[i];
                  cpg_pkg::OFS_ARM: rd_word[16:0] = arm_in_r[i];
                  cpg_pkg::OFS_COUNT: rd_word[cpg_pkg::CNT_W-1:0] = periods_v[i];
                  default: rd_word = 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // ==========================================================================
   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   // Pins are low in reset, the idle level of the reset settings.
   // Every channel has a pin of its own.
   assign pwm_out = out_v;

endmodule : cpg_top

// ### dv/cpg_top_properties.sv
/* Concurrent checks on the pins of cpg_top.
   Assumes an APB master that holds each request until pready. */
`timescale 1ns/1ps
module cpg_top_properties (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic [11:0] paddr, // address
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic [cpg_pkg::NUM_CH-1:0] pwm_out // output pins
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic run_r;
   logic [3:0] quiet_r;
   wire wr_done = psel && penable && pready && pwrite;
   // ==========================================================================
   // Run state and write quiet time, seen from the bus.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run_r <= 1'b0;
      else if (wr_done && paddr == cpg_pkg::ADDR_CTRL) run_r <= pwdata[0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) quiet_r <= 4'h0;
      else if (wr_done) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
   end
   // ==========================================================================
   // Bus and pin properties.
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   chk_ready_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("ready not one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_ready_cause: assert property (pready |-> $past(penable) && psel && penable)
      else $error("ready without access");
   chk_err_beyond: assert property (pready && (paddr >= 12'h0c0 || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("no error beyond map");
   chk_err_gap: assert property (pready && paddr >= 12'h020 && paddr < 12'h0c0
      && paddr[4:0] >= 5'h14 |-> pslverr) else $error("no error in channel gap");
   chk_ctrl_ok: assert property (pready && paddr == 12'h000 |-> !pslverr)
      else $error("error on control word");
   chk_err_data: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
      else $error("read data not zero");
   chk_idle_still: assert property (!run_r && quiet_r >= 4'h4 |-> $stable(pwm_out))
      else $error("pins move while stopped");
endmodule : cpg_top_properties

bind cpg_top cpg_top_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));

// ### dv/cpg_load_model.sv
/* Load on the counter pins: measures each pin's period and high time.
   Assumes the pins change only just after rising edges of pclk. */
`timescale 1ns/1ps
module cpg_load_model (
   input wire logic pclk, // sampling clock
   input wire logic presetn, // reset, active low
   input wire logic [cpg_pkg::NUM_CH-1:0] pins, // pins under test
   output int period_cyc [cpg_pkg::NUM_CH], // last rise to rise
   output int high_cyc [cpg_pkg::NUM_CH] // last rise to fall
);
   int cnt [cpg_pkg::NUM_CH];
   logic [cpg_pkg::NUM_CH-1:0] prev;
   // ==========================================================================
   // Pin timing, in pclk cycles.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= '0;
         for (int i = 0; i < cpg_pkg::NUM_CH; i++) begin
            cnt[i] <= 0;
            period_cyc[i] <= 0;
            high_cyc[i] <= 0;
         end
      end else begin
         prev <= pins;
         for (int i = 0; i < cpg_pkg::NUM_CH; i++) begin
            cnt[i] <= (pins[i] && !prev[i]) ? 1 : cnt[i] + 1;
            if (pins[i] && !prev[i]) period_cyc[i] <= cnt[i];
            if (!pins[i] && prev[i]) high_cyc[i] <= cnt[i];
         end
      end
   end
endmodule : cpg_load_model

// ### dv/test_cpg_top.sv
/* Self-checking bench for cpg_top over APB, timing every channel's pin.
   Assumes cpg_load_model on the pins and the bound checker. */
`timescale 1ns/1ps
module test_cpg_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [cpg_pkg::NUM_CH-1:0] pwm_out;
   int period_cyc [5];
   int high_cyc [5];
   int err_total = 0;
   int n_compared = 0;
   int cycles = 0;
   // Channel set-up: cfg, fixed word, input word, expected high time.
   localparam logic [31:0] CFG_T [5] = '{32'h00, 32'h04, 32'h08, 32'h02, 32'h61};
   localparam logic [31:0] FIX_T [5] = '{32'h4000, 32'h4000, 32'h8000, 32'h4000, 32'h4000};
   localparam logic [31:0] INP_T [5] = '{32'h8000, 32'h8000, 32'h8000, 32'h2000, 32'hc000};
   localparam int HIGH_T [5] = '{100, 1000, 5000, 100, 150};

   cpg_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
   cpg_load_model load (.pclk(pclk), .presetn(presetn), .pins(pwm_out),
      .period_cyc(period_cyc), .high_cyc(high_cyc));

   initial begin
      forever #10 pclk = ~pclk;
   end

   // ==========================================================================
   // Reporting and bus tasks.
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_int(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         err_total++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : chk_int
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp,
         input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk_word(what, exp, rd);
      chk_word("error flag", {31'h0, exp_err}, {31'h0, err});
   endtask : rd_chk
   function automatic logic [11:0] cha(input int n, input logic [4:0] ofs);
      return 12'(32 * n) + 12'(ofs);
   endfunction : cha

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_total++;
         report_and_stop();
      end
   end

   // ==========================================================================
   // Main sequence.
   initial begin
      repeat (8) @(posedge pclk);
      chk_word("pins in reset", 32'h0, 32'(pwm_out));
      presetn <= 1'b1;
      for (int n = 1; n <= 5; n++) begin
         rd_chk("cfg reset", cha(n, cpg_pkg::OFS_CFG), 32'h0, 1'b0);
         rd_chk("fixed reset", cha(n, cpg_pkg::OFS_FIXED), 32'h8000, 1'b0);
         rd_chk("input reset", cha(n, cpg_pkg::OFS_INPUT), 32'h0, 1'b0);
         rd_chk("arm reset", cha(n, cpg_pkg::OFS_ARM), 32'h0, 1'b0);
      end
      rd_chk("gap", cha(1, 5'h14), 32'h0, 1'b1);
      rd_chk("unaligned", 12'h002, 32'h0, 1'b1);
      rd_chk("beyond", 12'h0c0, 32'h0, 1'b1);
      for (int n = 0; n < 5; n++) begin
         wr(cha(n + 1, cpg_pkg::OFS_CFG), CFG_T[n]);
         wr(cha(n + 1, cpg_pkg::OFS_FIXED), FIX_T[n]);
         wr(cha(n + 1, cpg_pkg::OFS_INPUT), INP_T[n]);
      end
      rd_chk("fixed back", cha(2, cpg_pkg::OFS_FIXED), 32'h4000, 1'b0);
      repeat (4) @(posedge pclk);
      chk_word("idle pins", 32'h10, 32'(pwm_out));
      wr(cpg_pkg::ADDR_CTRL, 32'h1);
      // Two edges show the level set from the first phase, before any tick moves it.
      repeat (2) @(posedge pclk);
      chk_word("first phase", 32'h1f, 32'(pwm_out));
      wr(cha(2, cpg_pkg::OFS_FIXED), 32'h2000);
      rd_chk("fixed held", cha(2, cpg_pkg::OFS_FIXED), 32'h4000, 1'b0);
      repeat (25000) @(posedge pclk);
      for (int n = 0; n < 4; n++) begin
         // Period in pclk cycles is the base tick length over the step fraction.
         chk_int("period", cpg_pkg::REF_DIV * (10 ** int'(CFG_T[n][4:2])) * 65536 /
            int'(n == 3 ? INP_T[n] : FIX_T[n]), period_cyc[n]);
         chk_int("high time", HIGH_T[n], high_cyc[n]);
      end
      wr(cha(5, cpg_pkg::OFS_ARM), 32'h8000);
      repeat (2) @(posedge pclk);
      chk_word("armed low first", 32'h0, 32'(pwm_out[4]));
      repeat (600) @(posedge pclk);
      chk_int("armed period", 200, period_cyc[4]);
      chk_int("armed high", HIGH_T[4], high_cyc[4]);
      wr(cha(1, cpg_pkg::OFS_INPUT), 32'h4000);
      repeat (600) @(posedge pclk);
      chk_int("new duty", 50, high_cyc[0]);
      wr(cha(5, cpg_pkg::OFS_ARM), 32'h7fff);
      repeat (4) @(posedge pclk);
      chk_word("disarmed level", 32'h1, 32'(pwm_out[4]));
      wr(cpg_pkg::ADDR_CTRL, 32'h0);
      repeat (4) @(posedge pclk);
      chk_word("stopped pins", 32'h10, 32'(pwm_out));
      rd_chk("status stopped", cpg_pkg::ADDR_STATUS, 32'h200, 1'b0);
      wr(cha(1, cpg_pkg::OFS_INPUT), 32'hc000);
      for (int b = 3; b <= 4; b++) begin
         // Mode code 3 must run as plain pulse width.
         wr(cha(1, cpg_pkg::OFS_CFG), 32'(b * 4 + 3));
         wr(cpg_pkg::ADDR_CTRL, 32'h1);
         repeat (1000) @(posedge pclk);
         chk_word("slow base high", 32'h1, 32'(pwm_out[0]));
         wr(cpg_pkg::ADDR_CTRL, 32'h0);
      end
      report_and_stop();
   end
endmodule : test_cpg_top
